// [shared/wdog_pkg.sv]
// Purpose: Shared constants and state types for the software watchdog.
// Assumes: Firmware reaches the watchdog bits through special function register writes.
// Notes:   Window and divider counts are in core clock cycles; the watchdog count is in ticks.
package wdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the special function registers
  localparam int unsigned REFRESH_BIT  = 6;  // Refresh bit in interrupt_enable_reg0
  localparam int unsigned START_BIT    = 6;  // Start bit in interrupt_enable_reg1
  localparam int unsigned TIMEOUT_BIT  = 6;  // Status bit in interrupt_priority_reg0
  localparam int unsigned PRESCALE_BIT = 7;  // Extra divider select in reload register
  localparam int unsigned RELOAD_MSB   = 6;  // Top of the seven-bit reload value

  ////////////////////////////////////////////////////////////////////////////
  // Timing and terminal values
  localparam int unsigned BASE_DIV     = 24;  // Core cycles per count, short prescale
  localparam int unsigned EXTRA_DIV    = 16;  // Additional divider factor
  localparam int unsigned PRE_W        = 9;   // Wide enough for 24 * 16 - 1
  localparam logic [3:0]  WINDOW_CYC   = 4'hC;
  localparam logic [15:0] TERMINAL     = 16'h7CFF;
  localparam logic [7:0]  RELOAD_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic {
    wdog_idle,
    wdog_run
  } wdog_mode_t;

  typedef struct packed {
    wdog_mode_t  mode;
    logic [15:0] count;
    logic        refresh;
    logic [3:0]  refresh_cnt;
    logic        start;
    logic [3:0]  start_cnt;
    logic [7:0]  reload;
    logic        timeout;
  } wdog_state_t;

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } wdog_pre_t;

  localparam wdog_state_t STATE_RST = '0;
  localparam wdog_pre_t   PRE_RST   = '0;

endpackage

// [logic/wdog_prescale.sv]
// Purpose: Divides the core clock into the watchdog count tick.
// Assumes: run_i low holds the divider cleared.
// Notes:   Period is BASE_DIV cycles, or BASE_DIV * EXTRA_DIV with long_i set.
`timescale 1ns/10ps
module wdog_prescale #(
  parameter int unsigned BASE  = wdog_pkg::BASE_DIV,
  parameter int unsigned EXTRA = wdog_pkg::EXTRA_DIV
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic long_i,
  // Tick out
  output logic      tick_o
);

  localparam logic [wdog_pkg::PRE_W-1:0] LIM_SHORT = wdog_pkg::PRE_W'(BASE - 1);
  localparam logic [wdog_pkg::PRE_W-1:0] LIM_LONG  = wdog_pkg::PRE_W'(BASE * EXTRA - 1);

  wdog_pkg::wdog_pre_t st;
  wdog_pkg::wdog_pre_t next_st;
  logic [wdog_pkg::PRE_W-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // Tick on reaching the limit; >= catches a switch to the short period
  assign limit  = long_i ? LIM_LONG : LIM_SHORT;  // [RULE11]
  assign tick_o = run_i && (st.cnt >= limit);     // [RULE1]

  // Next divider value
  always_comb begin
    next_st = st;
    if (!run_i || tick_o) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // Divider register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= wdog_pkg::PRE_RST;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [logic/wdog_timer.sv]
// Purpose: Software watchdog counter with refresh window and reload register.
// Assumes: One-cycle SFR write strobes with shared write data from the core.
// Notes on behaviour
// [RULE1] 16-bit count every 24 or 384 cycles
// [RULE2] Reset clears counter, registers; watchdog idle
// [RULE3] Once running only reset stops it
// [RULE4] Start bit write starts idle watchdog
// [RULE5] Count 0x7CFF raises status and reset request
// [RULE6] Status drops on reset or count change
// [RULE7] Firmware sets start within 12 after refresh
// [RULE8] Start during refresh reloads; refresh bit clears
// [RULE9] Refresh bit self-clears 12 cycles after set
// [RULE10] Start bit self-clears 12 cycles after set
// [RULE11] Reload bit 7 adds divide-by-16 prescaler
// [RULE12] Reload bits 6-0 load counter high byte
// [RULE13] Reload register readable, writable any time
// [RULE14] Status readable as priority register bit 6
// [RULE15] Refresh clears low byte and counter MSB
`timescale 1ns/10ps
module wdog_timer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Special function register writes
  input  wire logic        interrupt_enable_reg0_wr_i,
  input  wire logic        interrupt_enable_one_wr_i,
  input  wire logic        reload_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  // Register read-back
  output logic             watchdog_refresh_bit_o,
  output logic             watchdog_start_bit_o,
  output logic             watchdog_timeout_status_o,
  output logic [7:0]       watchdog_reload_reg_o,
  output logic [15:0]      count_o,
  // Reset request to the system
  output logic             reset_request_o
);

  wdog_pkg::wdog_state_t st;
  wdog_pkg::wdog_state_t next_st;
  logic                  tick;
  logic                  refresh_evt;
  logic                  start_evt;
  logic                  running;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; a zero written to either bit is ignored
  assign refresh_evt = interrupt_enable_reg0_wr_i && sfr_wdata_i[wdog_pkg::REFRESH_BIT];
  assign start_evt   = interrupt_enable_one_wr_i && sfr_wdata_i[wdog_pkg::START_BIT];
  assign running     = (st.mode == wdog_pkg::wdog_run);

  // Count tick, divider held clear while idle
  wdog_prescale u_pre (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (running),
    .long_i  (st.reload[wdog_pkg::PRESCALE_BIT]),  // [RULE11]
    .tick_o  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Window timers run down and drop their bits
    if (st.refresh) begin
      if (st.refresh_cnt == 4'h1) begin
        next_st.refresh = 1'b0;                      // [RULE9]
      end else begin
        next_st.refresh_cnt = st.refresh_cnt - 1'b1;
      end
    end
    if (st.start) begin
      if (st.start_cnt == 4'h1) begin
        next_st.start = 1'b0;                        // [RULE10]
      end else begin
        next_st.start_cnt = st.start_cnt - 1'b1;
      end
    end
    if (refresh_evt) begin
      next_st.refresh     = 1'b1;
      next_st.refresh_cnt = wdog_pkg::WINDOW_CYC;
    end
    // Counting; a reload beats a tick in the same cycle
    if (running && tick) begin
      next_st.count = st.count + 1'b1;               // [RULE1]
    end
    if (start_evt) begin
      next_st.start     = 1'b1;
      next_st.start_cnt = wdog_pkg::WINDOW_CYC;
      // No path back to idle exists other than reset
      next_st.mode = wdog_pkg::wdog_run;             // [RULE4] [RULE3]
      if (st.refresh) begin
        // Relies on firmware pairing the two writes inside the window
        next_st.count   = {1'b0, st.reload[wdog_pkg::RELOAD_MSB:0], 8'h00}; // [RULE8] [RULE12] [RULE15] [RULE7]
        next_st.refresh = 1'b0;                      // [RULE8]
      end
    end
    if (reload_wr_i) begin
      next_st.reload = sfr_wdata_i;                  // [RULE13]
    end
    // Registered status follows the next count, so it tracks it exactly
    next_st.timeout = (next_st.mode == wdog_pkg::wdog_run) &&
                      (next_st.count == wdog_pkg::TERMINAL); // [RULE5] [RULE6]
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= wdog_pkg::STATE_RST;                     // [RULE2]
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign watchdog_refresh_bit_o    = st.refresh;
  assign watchdog_start_bit_o      = st.start;
  assign watchdog_timeout_status_o = st.timeout;     // [RULE14]
  assign watchdog_reload_reg_o     = st.reload;      // [RULE13]
  assign count_o                   = st.count;
  assign reset_request_o           = st.timeout;     // [RULE5]

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters for the checks below
  logic [3:0] refresh_age;
  logic [3:0] start_age;
  logic [8:0] tick_gap;
  logic       sel_moved;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      refresh_age <= '0;
      start_age   <= '0;
      tick_gap    <= '0;
      sel_moved   <= 1'b1;
    end else begin
      refresh_age <= refresh_evt ? 4'h0 : refresh_age + 1'b1;
      start_age   <= start_evt ? 4'h0 : start_age + 1'b1;
      tick_gap    <= (tick || !running) ? 9'h000 : tick_gap + 1'b1;
      if (tick || !running) begin
        sel_moved <= 1'b0;
      end else if (next_st.reload[7] != st.reload[7]) begin
        sel_moved <= 1'b1;
      end
    end
  end

  // Reset clears every field of the state register
  property p_reset;
    @(posedge clk_i) !rst_n_i |=> (st == wdog_pkg::STATE_RST);
  endproperty
  a_reset: assert property (p_reset) else $error("state not cleared by reset"); // [RULE2]

  // Running never returns to idle without reset
  property p_no_stop;
    @(posedge clk_i) disable iff (!rst_n_i) running |=> running;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("watchdog stopped"); // [RULE3]

  // Start write wakes an idle watchdog
  property p_start;
    @(posedge clk_i) disable iff (!rst_n_i) (!running && start_evt) |=> running;
  endproperty
  a_start: assert property (p_start) else $error("start did not run"); // [RULE4]

  // Status and reset request exactly at the terminal count
  property p_timeout;
    @(posedge clk_i) disable iff (!rst_n_i)
      reset_request_o == (running && count_o == 16'h7CFF) &&
      watchdog_timeout_status_o == reset_request_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout status wrong"); // [RULE5]

  // Status falls once the count moves on
  property p_deassert;
    @(posedge clk_i) disable iff (!rst_n_i)
      watchdog_timeout_status_o ##1 (count_o != $past(count_o)) |-> !watchdog_timeout_status_o;
  endproperty
  a_deassert: assert property (p_deassert) else $error("status held after change"); // [RULE6]

  // Refresh pair reloads the high byte and clears the refresh bit
  property p_reload_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_evt && watchdog_refresh_bit_o && !refresh_evt) |=>
      count_o == {1'b0, $past(watchdog_reload_reg_o[6:0]), 8'h00} && !watchdog_refresh_bit_o;
  endproperty
  a_reload_load: assert property (p_reload_load) else $error("refresh load wrong"); // [RULE8]

  // Refresh bit lives exactly twelve cycles unless consumed
  property p_refresh_life;
    @(posedge clk_i) disable iff (!rst_n_i)
      ($fell(watchdog_refresh_bit_o) && !$past(start_evt)) |-> ($past(refresh_age) == 4'd11);
  endproperty
  a_refresh_life: assert property (p_refresh_life) else $error("refresh bit life"); // [RULE9]

  // Start bit lives exactly twelve cycles; it is never consumed early
  property p_start_life;
    @(posedge clk_i) disable iff (!rst_n_i)
      (watchdog_start_bit_o |-> (start_age <= 4'd11)) and
      ($fell(watchdog_start_bit_o) |-> ($past(start_age) == 4'd11));
  endproperty
  a_start_life: assert property (p_start_life) else $error("start bit too long"); // [RULE10]

  // Tick spacing follows the prescale select
  property p_tick_gap;
    @(posedge clk_i) disable iff (!rst_n_i)
      (tick && !sel_moved) |-> (tick_gap == (st.reload[7] ? 9'd383 : 9'd23));
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong"); // [RULE11]

  // Reload writes land at any time
  property p_reload_wr;
    @(posedge clk_i) disable iff (!rst_n_i)
      reload_wr_i |=> watchdog_reload_reg_o == $past(sfr_wdata_i);
  endproperty
  a_reload_wr: assert property (p_reload_wr) else $error("reload write lost"); // [RULE13]

endmodule

// [testbench/wdog_fw_model.sv]
// Purpose: Firmware side model that writes the watchdog registers.
// Assumes: Called just after a falling edge; strobes last one cycle.
// Notes:   Released data shows the inverse value, never the last one.
`timescale 1ns/10ps
module wdog_fw_model (
  // Clock
  input  wire logic clk_i,
  // Register writes
  output logic       interrupt_enable_reg0_wr_o,
  output logic       interrupt_enable_one_wr_o,
  output logic       reload_wr_o,
  output logic [7:0] wdata_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    interrupt_enable_reg0_wr_o   = 1'h0;
    interrupt_enable_one_wr_o   = 1'h0;
    reload_wr_o = 1'h0;
    wdata_o     = 8'h00;
  end

  // One write: 0 refresh reg, 1 start reg, 2 reload; a spare cycle after
  // each so no strobe is raised again at the edge that lowers it
  task automatic wr(input int sel, input logic [7:0] d);
    interrupt_enable_reg0_wr_o   = (sel == 0);
    interrupt_enable_one_wr_o   = (sel == 1);
    reload_wr_o = (sel == 2);
    wdata_o     = d;
    @(negedge clk_i);
    interrupt_enable_reg0_wr_o   = 1'h0;
    interrupt_enable_one_wr_o   = 1'h0;
    reload_wr_o = 1'h0;
    wdata_o     = ~d;
    @(negedge clk_i);
  endtask

  // Refresh pair, start taken two cycles after refresh
  task automatic refresh();
    wr(0, 8'h40);
    wr(1, 8'h40);
  endtask
endmodule

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the software watchdog.
// Assumes: Inputs change at the falling edge only.
// Notes:   Terminal count run takes about 6100 cycles.
`timescale 1ns/10ps
module testbench;
  logic        clk_i   = 1'h0;
  logic        rst_n_i = 1'h0;
  logic        interrupt_enable_reg0_wr, interrupt_enable_one_wr, reload_wr, refresh_q, start_q, status_q, req_q;
  logic [7:0]  wdata, reload_q;
  logic [15:0] count_q, v;
  int          miscompares = 0;
  int          tests_run   = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial forever #2.5 clk_i = ~clk_i;

  wdog_fw_model fw (.clk_i(clk_i), .interrupt_enable_reg0_wr_o(interrupt_enable_reg0_wr), .interrupt_enable_one_wr_o(interrupt_enable_one_wr),
    .reload_wr_o(reload_wr), .wdata_o(wdata));

  wdog_timer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .interrupt_enable_reg0_wr_i(interrupt_enable_reg0_wr),
    .interrupt_enable_one_wr_i(interrupt_enable_one_wr), .reload_wr_i(reload_wr), .sfr_wdata_i(wdata),
    .watchdog_refresh_bit_o(refresh_q), .watchdog_start_bit_o(start_q),
    .watchdog_timeout_status_o(status_q), .watchdog_reload_reg_o(reload_q),
    .count_o(count_q), .reset_request_o(req_q));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bounded wait; running out shows up as a miscompare
  task automatic wait_cnt(input logic [15:0] val);
    for (int i = 0; i < 20000 && count_q !== val; i++) cyc(1);
    chk(count_q, val);
  endtask

  // Measures one full tick period, not the partial one after a change
  task automatic period(input int div);
    wait_cnt(count_q + 16'h0001);
    v = count_q;
    cyc(div - 4);
    chk(count_q, v);
    cyc(8);
    chk(count_q, v + 16'h0001);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well beyond the expected 7100 cycles
  initial begin
    #100_000;
    miscompares++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(12);
    rst_n_i = 1'h1;
    cyc(1);
    chk(16'({refresh_q, start_q, status_q, req_q}), 16'h0000);
    chk(count_q, 16'h0000);
    chk(16'(reload_q), 16'h0000);
    fw.wr(1, 8'h40);
    cyc(10);
    chk(16'(start_q), 16'h0001);
    cyc(1);
    chk(16'(start_q), 16'h0000);
    period(24);
    fw.wr(2, 8'h85);
    chk(16'(reload_q), 16'h0085);
    fw.wr(0, 8'h40);
    chk(16'(refresh_q), 16'h0001);
    fw.wr(1, 8'h40);
    chk(16'(refresh_q), 16'h0000);
    chk({count_q[15:1], 1'h0}, 16'h0500);
    // Window runs out; a late start must not reload
    fw.wr(2, 8'h22);
    fw.wr(0, 8'h40);
    cyc(10);
    chk(16'(refresh_q), 16'h0001);
    cyc(1);
    chk(16'(refresh_q), 16'h0000);
    fw.wr(1, 8'h40);
    chk(16'(count_q[15:8]), 16'h0005);
    fw.wr(1, 8'h00);
    chk(16'(start_q), 16'h0001);
    fw.wr(0, 8'h00);
    period(24);
    fw.refresh();
    chk(16'(count_q[15:8]), 16'h0022);
    // Terminal value drives status and reset request
    fw.wr(2, 8'h7C);
    fw.refresh();
    wait_cnt(16'h7CFE);
    chk(16'({status_q, req_q}), 16'h0000);
    wait_cnt(16'h7CFF);
    chk(16'({status_q, req_q}), 16'h0003);
    wait_cnt(16'h7D00);
    chk(16'({status_q, req_q}), 16'h0000);
    fw.wr(2, 8'h80);
    chk(16'(reload_q), 16'h0080);
    period(384);
    // Only reset stops a running watchdog
    rst_n_i = 1'h0;
    cyc(2);
    rst_n_i = 1'h1;
    cyc(30);
    chk(count_q, 16'h0000);
    chk(16'(reload_q), 16'h0000);
    wrap_up();
  end
endmodule
